// File: hdl/irq_buf_ctrl.sv
/*
 * Sample buffer with mode control, interrupt routing and serial registers.
 * Assumes samples, data-ready, threshold events, trigger and soft reset
 * come from logic on clk_sys_i; the serial port pins are asynchronous.
 */
`timescale 1ns/1ps

// ==========================================================
// Buffer storage
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             flush_i,
	input  wire logic             overwrite_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [AW:0]           level_o,
	output logic                  full_o,
	output logic                  dropped_o
);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      level_ff;
	logic             push;
	logic             pop;
	logic             drop;

	assign full_o      = (level_ff == (AW+1)'(DEPTH));
	assign in_ready_o  = !full_o || overwrite_i || out_ready_i;
	assign out_valid_o = (level_ff != '0);
	assign out_data_o  = mem_ff[rd_ptr_ff];
	assign level_o     = level_ff;
	assign push        = in_valid_i && in_ready_o && !flush_i;
	// Oldest entry leaves when a push arrives while full and the reader is not taking it
	assign drop        = push && full_o && !out_ready_i;
	assign pop         = (out_valid_o && out_ready_i && !flush_i) || drop;
	assign dropped_o   = drop;

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_sys_i) begin
			if (push && wr_ptr_ff == AW'(i)) begin
				mem_ff[i] <= in_data_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			level_ff  <= '0;
		end else if (flush_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			level_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				level_ff <= level_ff + 1'b1;
			end else if (pop && !push) begin
				level_ff <= level_ff - 1'b1;
			end
		end
	end
endmodule

// ==========================================================
// Control top
module irq_buf_ctrl #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	input  wire logic             soft_rst_i,
	input  wire logic             sclk_i,
	input  wire logic             cs_n_i,
	input  wire logic             mosi_i,
	output logic                  miso_o,
	output logic                  miso_oe_n_o,
	input  wire logic             sample_valid_i,
	output logic                  sample_ready_o,
	input  wire logic [WIDTH-1:0] sample_data_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [WIDTH-1:0]      rd_data_o,
	input  wire logic             new_sample_i,
	input  wire logic             p_high_i,
	input  wire logic             p_low_i,
	input  wire logic             trigger_i,
	output logic                  irq_o,
	output logic                  irq_oe_n_o
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0]  irq_ctrl_ff;
	logic [7:0]  buf_ctrl_ff;
	logic [2:0]  sclk_sync_ff;
	logic [2:0]  cs_sync_ff;
	logic [2:0]  mosi_sync_ff;
	logic        sclk_flt_ff;
	logic        cs_n_flt_ff;
	logic        mosi_flt_ff;
	logic        sclk_prev_ff;
	logic [3:0]  bit_cnt_ff;
	logic [7:0]  rx_ff;
	logic [7:0]  cmd_ff;
	logic [7:0]  tx_ff;
	logic        trig_prev_ff;
	logic        trig_seen_ff;
	logic        overrun_ff;
	logic        irq_ff;
	logic        oe_n_ff;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        reg_wr;
	logic        buf_wr;
	logic [7:0]  rd_data;
	logic [2:0]  mode;
	logic [4:0]  watermark_level;
	irq_buf_pkg::eff_mode_t eff;
	logic        flush;
	logic        fifo_in_ready;
	logic [AW:0] level;
	logic        full;
	logic        dropped;
	logic        wtm_hit;
	logic [1:0]  src_sel;
	logic        data_sig;
	logic        irq_raw;

	// ==========================================================
	// Pin synchronisers, change taken once stages two and three agree
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sync_ff <= 3'h0;
			cs_sync_ff   <= 3'h7;
			mosi_sync_ff <= 3'h0;
			sclk_flt_ff  <= 1'b0;
			cs_n_flt_ff  <= 1'b1;
			mosi_flt_ff  <= 1'b0;
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_i};
			cs_sync_ff   <= {cs_sync_ff[1:0], cs_n_i};
			mosi_sync_ff <= {mosi_sync_ff[1:0], mosi_i};
			if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
				sclk_flt_ff <= sclk_sync_ff[2];
			end
			if (cs_sync_ff[1] == cs_sync_ff[2]) begin
				cs_n_flt_ff <= cs_sync_ff[2];
			end
			if (mosi_sync_ff[1] == mosi_sync_ff[2]) begin
				mosi_flt_ff <= mosi_sync_ff[2];
			end
			sclk_prev_ff <= sclk_flt_ff;
		end
	end

	assign sclk_rise = !cs_n_flt_ff && sclk_flt_ff && !sclk_prev_ff;
	assign sclk_fall = !cs_n_flt_ff && !sclk_flt_ff && sclk_prev_ff;

	// ==========================================================
	// Serial frame: command byte then data byte, MSB first
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_ff <= 4'h0;
			rx_ff      <= 8'h00;
			cmd_ff     <= 8'h00;
		end else if (cs_n_flt_ff) begin
			bit_cnt_ff <= 4'h0;
		end else if (sclk_rise) begin
			rx_ff      <= {rx_ff[6:0], mosi_flt_ff};
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
			if (bit_cnt_ff == irq_buf_pkg::CMD_LAST_BIT) begin
				cmd_ff <= {rx_ff[6:0], mosi_flt_ff};
			end
		end
	end

	assign reg_wr = sclk_rise && (bit_cnt_ff == irq_buf_pkg::FRAME_LAST)
		&& !cmd_ff[irq_buf_pkg::CMD_READ_BIT];

	always_comb begin
		unique case (cmd_ff[6:0])
			irq_buf_pkg::IRQ_PIN_CTRL_ADDR: rd_data = irq_ctrl_ff;
			irq_buf_pkg::BUF_CTRL_ADDR:     rd_data = buf_ctrl_ff;
			default:                        rd_data = irq_buf_pkg::UNMAPPED_READ;
		endcase
	end

	// Read data loaded on the falling edge after the command byte
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_ff <= 8'h00;
		end else if (sclk_fall) begin
			if (bit_cnt_ff == irq_buf_pkg::DATA_FIRST
				&& cmd_ff[irq_buf_pkg::CMD_READ_BIT]) begin
				tx_ff <= rd_data;
			end else begin
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	assign miso_o      = tx_ff[7];
	assign miso_oe_n_o = cs_n_flt_ff;

	// ==========================================================
	// Registers; soft reset restores defaults
	assign buf_wr = reg_wr && (cmd_ff[6:0] == irq_buf_pkg::BUF_CTRL_ADDR);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_ctrl_ff <= irq_buf_pkg::IRQ_PIN_CTRL_RST;
		end else if (soft_rst_i) begin
			irq_ctrl_ff <= irq_buf_pkg::IRQ_PIN_CTRL_RST;
		end else if (reg_wr && cmd_ff[6:0] == irq_buf_pkg::IRQ_PIN_CTRL_ADDR) begin
			irq_ctrl_ff <= {rx_ff[6:0], mosi_flt_ff};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_ctrl_ff <= irq_buf_pkg::BUF_CTRL_RST;
		end else if (soft_rst_i) begin
			buf_ctrl_ff <= irq_buf_pkg::BUF_CTRL_RST;
		end else if (buf_wr) begin
			buf_ctrl_ff <= {rx_ff[6:0], mosi_flt_ff};
		end
	end

	assign mode = buf_ctrl_ff[irq_buf_pkg::MODE_HI_BIT:irq_buf_pkg::MODE_LO_BIT];
	assign watermark_level =
		buf_ctrl_ff[irq_buf_pkg::WTM_HI_BIT:irq_buf_pkg::WTM_LO_BIT];

	// ==========================================================
	// Trigger deassertion, re-armed by every mode write
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trig_prev_ff <= 1'b0;
			trig_seen_ff <= 1'b0;
		end else begin
			trig_prev_ff <= trigger_i;
			// A fall in the cycle of a mode write still counts
			if (soft_rst_i) begin
				trig_seen_ff <= 1'b0;
			end else if (trig_prev_ff && !trigger_i) begin
				trig_seen_ff <= 1'b1;
			end else if (buf_wr) begin
				trig_seen_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (mode)
			irq_buf_pkg::MODE_BYPASS:
				eff = irq_buf_pkg::EFF_BYPASS;
			irq_buf_pkg::MODE_FILL_ONCE:
				eff = irq_buf_pkg::EFF_FILL_ONCE;
			irq_buf_pkg::MODE_STREAM:
				eff = irq_buf_pkg::EFF_STREAM;
			irq_buf_pkg::MODE_STR_TO_FILL:
				eff = trig_seen_ff ? irq_buf_pkg::EFF_FILL_ONCE
					: irq_buf_pkg::EFF_STREAM;
			irq_buf_pkg::MODE_BYP_TO_STR:
				eff = trig_seen_ff ? irq_buf_pkg::EFF_STREAM
					: irq_buf_pkg::EFF_BYPASS;
			irq_buf_pkg::MODE_RESERVED:
				eff = irq_buf_pkg::EFF_BYPASS;
			// Dynamic behaviour unknown here; plain streaming is the safe guess
			irq_buf_pkg::MODE_DYN_STREAM:
				eff = irq_buf_pkg::EFF_STREAM;
			irq_buf_pkg::MODE_BYP_TO_FILL:
				eff = trig_seen_ff ? irq_buf_pkg::EFF_FILL_ONCE
					: irq_buf_pkg::EFF_BYPASS;
		endcase
	end

	// Held flush while in bypass also covers every entry into it
	assign flush = (eff == irq_buf_pkg::EFF_BYPASS)
		|| soft_rst_i;

	sample_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (flush),
		.overwrite_i (eff == irq_buf_pkg::EFF_STREAM),
		.in_valid_i  (sample_valid_i),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (sample_data_i),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o),
		.level_o     (level),
		.full_o      (full),
		.dropped_o   (dropped)
	);

	// Bypass discards samples, so the source is never stalled there
	assign sample_ready_o = flush || fifo_in_ready;

	// ==========================================================
	// Status and interrupt routing
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overrun_ff <= 1'b0;
		end else if (dropped) begin
			overrun_ff <= 1'b1;
		end else if (flush) begin
			overrun_ff <= 1'b0;
		end
	end

	assign wtm_hit = (level >= {1'b0, watermark_level});
	assign src_sel = {irq_ctrl_ff[irq_buf_pkg::SRC_SEL_HI_BIT],
		irq_ctrl_ff[irq_buf_pkg::SRC_SEL_LO_BIT]};
	// Priority order only matters for reporting; the pin shows their OR
	assign data_sig =
		(irq_ctrl_ff[irq_buf_pkg::NEW_ROUTE_BIT] && new_sample_i)
		|| (irq_ctrl_ff[irq_buf_pkg::WTM_ROUTE_BIT] && wtm_hit)
		|| (irq_ctrl_ff[irq_buf_pkg::OVR_ROUTE_BIT] && overrun_ff)
		|| (irq_ctrl_ff[irq_buf_pkg::FULL_ROUTE_BIT] && full);

	always_comb begin
		unique case (src_sel)
			irq_buf_pkg::SRC_DATA:  irq_raw = data_sig;
			irq_buf_pkg::SRC_PHIGH: irq_raw = p_high_i;
			irq_buf_pkg::SRC_PLOW:  irq_raw = p_low_i;
			irq_buf_pkg::SRC_PANY:  irq_raw = p_high_i || p_low_i;
		endcase
	end

	// Open drain only ever pulls low, so a high level releases the pin
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_ff  <= 1'b0;
			oe_n_ff <= 1'b0;
		end else begin
			irq_ff  <= irq_raw ^ irq_ctrl_ff[irq_buf_pkg::IRQ_POL_BIT];
			oe_n_ff <= irq_ctrl_ff[irq_buf_pkg::IRQ_DRIVE_BIT]
				&& (irq_raw ^ irq_ctrl_ff[irq_buf_pkg::IRQ_POL_BIT]);
		end
	end

	assign irq_o      = irq_ff;
	assign irq_oe_n_o = oe_n_ff;

	// ==========================================================
	// Checks
	property p_irq_pol;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!irq_ctrl_ff[irq_buf_pkg::IRQ_POL_BIT] ##0 irq_raw |=> irq_o;
	endproperty
	a_irq_pol: assert property (p_irq_pol)
		else $error("Interrupt polarity wrong");

	property p_open_drain;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$past(irq_ctrl_ff[irq_buf_pkg::IRQ_DRIVE_BIT]) && irq_o |-> irq_oe_n_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("Open drain pin driven high");

	property p_wtm;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		src_sel == 2'h0 && irq_ctrl_ff[irq_buf_pkg::WTM_ROUTE_BIT]
		&& level >= {1'b0, watermark_level} |-> irq_raw;
	endproperty
	a_wtm: assert property (p_wtm)
		else $error("Watermark not shown");

	property p_overrun;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		dropped |=> overrun_ff;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("Overrun not flagged");

	property p_newsample;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		src_sel == 2'h0 && irq_ctrl_ff[irq_buf_pkg::NEW_ROUTE_BIT]
		&& new_sample_i |-> irq_raw;
	endproperty
	a_newsample: assert property (p_newsample)
		else $error("Data ready not shown");

	property p_psel;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		src_sel == 2'h3 |-> irq_raw == (p_high_i || p_low_i);
	endproperty
	a_psel: assert property (p_psel)
		else $error("Pressure event select wrong");

	property p_bypass;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		eff == irq_buf_pkg::EFF_BYPASS |=> level == '0;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("Bypass did not flush");

	property p_fill_stop;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		eff == irq_buf_pkg::EFF_FILL_ONCE && full && !rd_ready_i
		|-> !sample_ready_o;
	endproperty
	a_fill_stop: assert property (p_fill_stop)
		else $error("Fill-once kept collecting");

	property p_stream_full;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		eff == irq_buf_pkg::EFF_STREAM && full && sample_valid_i
		&& !rd_ready_i
		&& !soft_rst_i |-> dropped ##1 full;
	endproperty
	a_stream_full: assert property (p_stream_full)
		else $error("Stream did not overwrite");

	property p_trig_switch;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		mode == 3'h7 && trig_prev_ff && !trigger_i && !buf_wr && !soft_rst_i
		|=> (eff == irq_buf_pkg::EFF_FILL_ONCE) [*2];
	endproperty
	a_trig_switch: assert property (p_trig_switch)
		else $error("Trigger switch missed");

	property p_soft_rst;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		soft_rst_i |=> level == '0 && buf_ctrl_ff == 8'h00 && irq_ctrl_ff == 8'h00;
	endproperty
	a_soft_rst: assert property (p_soft_rst)
		else $error("Soft reset incomplete");
endmodule

// File: inc/irq_buf_pkg.sv
/*
 * Constants, register map and mode codes of the sample buffer control block.
 * Assumes a serial control port that carries an 8-bit command byte
 * (read flag and 7-bit address) followed by one data byte.
 */
package irq_buf_pkg;

	// ==========================================================
	// Register map
	localparam logic [6:0] IRQ_PIN_CTRL_ADDR = 7'h12;
	localparam logic [6:0] BUF_CTRL_ADDR     = 7'h14;
	localparam logic [7:0] IRQ_PIN_CTRL_RST  = 8'h00;
	localparam logic [7:0] BUF_CTRL_RST      = 8'h00;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;

	// ==========================================================
	// Interrupt pin control fields
	localparam int IRQ_POL_BIT       = 7;
	localparam int IRQ_DRIVE_BIT     = 6;
	localparam int FULL_ROUTE_BIT    = 5;
	localparam int WTM_ROUTE_BIT     = 4;
	localparam int OVR_ROUTE_BIT     = 3;
	localparam int NEW_ROUTE_BIT     = 2;
	localparam int SRC_SEL_HI_BIT    = 1;
	localparam int SRC_SEL_LO_BIT    = 0;
	localparam logic [1:0] SRC_DATA  = 2'h0;
	localparam logic [1:0] SRC_PHIGH = 2'h1;
	localparam logic [1:0] SRC_PLOW  = 2'h2;
	localparam logic [1:0] SRC_PANY  = 2'h3;

	// ==========================================================
	// Buffer control fields and mode codes
	localparam int MODE_HI_BIT       = 7;
	localparam int MODE_LO_BIT       = 5;
	localparam int WTM_HI_BIT        = 4;
	localparam int WTM_LO_BIT        = 0;
	localparam logic [2:0] MODE_BYPASS      = 3'h0;
	localparam logic [2:0] MODE_FILL_ONCE   = 3'h1;
	localparam logic [2:0] MODE_STREAM      = 3'h2;
	localparam logic [2:0] MODE_STR_TO_FILL = 3'h3;
	localparam logic [2:0] MODE_BYP_TO_STR  = 3'h4;
	localparam logic [2:0] MODE_RESERVED    = 3'h5;
	localparam logic [2:0] MODE_DYN_STREAM  = 3'h6;
	localparam logic [2:0] MODE_BYP_TO_FILL = 3'h7;

	// ==========================================================
	// Serial frame
	localparam int CMD_READ_BIT          = 7;
	localparam logic [3:0] CMD_LAST_BIT  = 4'h7;
	localparam logic [3:0] DATA_FIRST    = 4'h8;
	localparam logic [3:0] FRAME_LAST    = 4'hf;

	typedef enum logic [1:0] {
		EFF_BYPASS,
		EFF_FILL_ONCE,
		EFF_STREAM
	} eff_mode_t;

endpackage

// File: test/fifo_mode_and_irq_routing_tb.sv
/*
 * Self-checking bench of the buffer control and interrupt routing block.
 * Assumes the host model drives the serial port and an external pull-up
 * sits on the interrupt pin.
 */
`timescale 1ns/1ps

`define CHK(what, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("BAD %s exp %h got %h", what, exp, got); \
		end \
	end

module fifo_mode_and_irq_routing_tb;
	localparam int         W     = 8;
	localparam logic [6:0] A_IRQ = irq_buf_pkg::IRQ_PIN_CTRL_ADDR;
	localparam logic [6:0] A_BUF = irq_buf_pkg::BUF_CTRL_ADDR;
	logic         clk_sys_i, rst_n_i, soft_rst_i, trigger_i;
	logic         sclk, cs_n, mosi, miso, miso_oe_n;
	logic         sample_valid_i, sample_ready_o, rd_valid_o, rd_ready_i;
	logic [W-1:0] sample_data_i, rd_data_o;
	logic         new_sample_i, p_high_i, p_low_i, irq_o, irq_oe_n_o;
	logic         pin, raw;
	logic [7:0]   rdat;
	logic [2:0]   modes [3] = '{3'h3, 3'h4, 3'h7};
	logic [7:0]   first_exp [3] = '{8'h03, 8'h43, 8'h41};
	int           n_mismatch = 0;
	int           check_count = 0;

	// ==========================================================
	// Clock, pin and instances
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// Open drain released means pulled up
	assign pin = irq_oe_n_o ? 1'b1 : irq_o;

	irq_buf_ctrl #(.WIDTH(W), .DEPTH(8)) dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
		.miso_oe_n_o(miso_oe_n), .sample_valid_i(sample_valid_i),
		.sample_ready_o(sample_ready_o), .sample_data_i(sample_data_i),
		.rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
		.rd_data_o(rd_data_o), .new_sample_i(new_sample_i),
		.p_high_i(p_high_i), .p_low_i(p_low_i), .trigger_i(trigger_i),
		.irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));

	host_link_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_n_i(miso_oe_n));

	// ==========================================================
	// Tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		host.rd(a, rdat);
		`CHK("register", exp, rdat)
	endtask

	// Bounded wait; pin is registered one cycle behind its cause
	task automatic pin_chk(input logic exp);
		int n;
		n = 0;
		while (pin !== exp && n < 8) begin
			@(negedge clk_sys_i);
			n++;
		end
		`CHK("irq pin", exp, pin)
	endtask

	task automatic push(input int n, input logic [W-1:0] base);
		@(negedge clk_sys_i);
		for (int i = 0; i < n; i++) begin
			sample_valid_i = 1'b1;
			sample_data_i = base + W'(i);
			@(negedge clk_sys_i);
		end
		sample_valid_i = 1'b0;
		@(negedge clk_sys_i);
	endtask

	task automatic pop(input int n, input logic [W-1:0] first);
		@(negedge clk_sys_i);
		for (int i = 0; i < n; i++) begin
			`CHK("rd valid", 1'b1, rd_valid_o)
			`CHK("rd data", first + W'(i), rd_data_o)
			rd_ready_i = 1'b1;
			@(negedge clk_sys_i);
			rd_ready_i = 1'b0;
		end
		`CHK("rd empty", 1'b0, rd_valid_o)
	endtask

	initial begin
		#200us;
		n_mismatch++;
		$display("BAD watchdog expired");
		tally_and_finish();
	end

	// ==========================================================
	// Tests
	initial begin
		{soft_rst_i, sample_valid_i, rd_ready_i, new_sample_i} = '0;
		{p_high_i, p_low_i, trigger_i} = '0;
		sample_data_i = '0;
		rst_n_i = 1'b0;
		repeat (12) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		rd_chk(A_IRQ, 8'h00);
		rd_chk(A_BUF, 8'h00);
		rd_chk(7'h13, 8'h00);
		pin_chk(1'b0);
		host.wr(A_IRQ, 8'h5a);
		rd_chk(A_IRQ, 8'h5a);
		$display("test registers done");

		// Every pressure event select (1 to 3) under both polarities and drives
		for (int m = 0; m < 16; m++) begin
			if (m[1:0] == 2'h0)
				continue;
			host.wr(A_IRQ, {m[3:2], 4'h0, m[1:0]});
			for (int e = 0; e < 4; e++) begin
				@(negedge clk_sys_i);
				{p_low_i, p_high_i} = e[1:0];
				raw = (m[0] & e[0]) | (m[1] & e[1]);
				pin_chk(raw ^ m[3]);
				`CHK("irq drive", m[2] & (raw ^ m[3]), irq_oe_n_o)
			end
		end
		{p_low_i, p_high_i} = 2'h0;
		host.wr(A_IRQ, 8'h04);
		// Host frames end off the clock grid
		@(negedge clk_sys_i);
		new_sample_i = 1'b1;
		pin_chk(1'b1);
		new_sample_i = 1'b0;
		pin_chk(1'b0);
		$display("test routing done");

		host.wr(A_BUF, 8'h24);
		host.wr(A_IRQ, 8'h10);
		push(3, 8'h01);
		pin_chk(1'b0);
		push(1, 8'h04);
		pin_chk(1'b1);
		host.wr(A_IRQ, 8'h20);
		pin_chk(1'b0);
		push(6, 8'h05);
		pin_chk(1'b1);
		`CHK("full refuses", 1'b0, sample_ready_o)
		pop(8, 8'h01);
		$display("test fill once done");

		host.wr(A_BUF, 8'h40);
		host.wr(A_IRQ, 8'h08);
		push(8, 8'h01);
		pin_chk(1'b0);
		push(2, 8'h09);
		pin_chk(1'b1);
		pop(8, 8'h03);
		push(3, 8'h20);
		host.wr(A_BUF, 8'h00);
		@(negedge clk_sys_i);
		`CHK("flushed", 1'b0, rd_valid_o)
		push(2, 8'h30);
		`CHK("bypass ready", 1'b1, sample_ready_o)
		`CHK("bypass empty", 1'b0, rd_valid_o)
		// Mode 110 runs as plain streaming; 101 is kept out by the host
		host.wr(A_BUF, 8'hc0);
		push(10, 8'h01);
		`CHK("mode 110 ready", 1'b1, sample_ready_o)
		pop(8, 8'h03);
		host.wr(A_BUF, 8'ha4);
		rd_chk(A_BUF, 8'h04);
		$display("test stream and bypass done");

		// Trigger held during the mode write, then dropped
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys_i);
			trigger_i = 1'b1;
			host.wr(A_BUF, {modes[k], 5'h00});
			push(10, 8'h01);
			`CHK("before fall", k == 0, rd_valid_o)
			trigger_i = 1'b0;
			repeat (2) @(negedge clk_sys_i);
			push(10, 8'h41);
			`CHK("after fall", k == 1, sample_ready_o)
			pop(8, first_exp[k]);
		end
		$display("test trigger modes done");

		host.wr(A_BUF, 8'h40);
		host.wr(A_IRQ, 8'h04);
		push(3, 8'h01);
		soft_rst_i = 1'b1;
		@(negedge clk_sys_i);
		soft_rst_i = 1'b0;
		@(negedge clk_sys_i);
		`CHK("soft flush", 1'b0, rd_valid_o)
		rd_chk(A_BUF, 8'h00);
		rd_chk(A_IRQ, 8'h00);
		$display("test soft reset done");
		tally_and_finish();
	end
endmodule

// File: test/host_link_model.sv
/*
 * Host processor model: frames register accesses on the serial port.
 * Assumes the device samples these pins with its own clock and shifts
 * read data out on falling serial clock edges.
 */
`timescale 1ns/1ps

// ==========================================================
// Serial host
module host_link_model (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i,
	input  wire logic miso_oe_n_i
);
	localparam int HALF = 32;
	logic miso_line;

	// Released line shows the inverse of miso_i
	assign miso_line = miso_oe_n_i ? ~miso_i : miso_i;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	task automatic xfer(input logic [15:0] frame, output logic [7:0] dout);
		cs_n_o = 1'b0;
		#HALF;
		for (int i = 15; i >= 0; i--) begin
			sclk_o = 1'b0;
			mosi_o = frame[i];
			#HALF;
			if (i < 8)
				dout[i] = miso_line;
			sclk_o = 1'b1;
			#HALF;
		end
		sclk_o = 1'b0;
		mosi_o = ~mosi_o;
		#HALF;
		cs_n_o = 1'b1;
		// Long gap so the write lands before the next access
		#(3*HALF);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] nc;
		logic [7:0] v;
		v = d;
		if (a == irq_buf_pkg::BUF_CTRL_ADDR && v[7:5] == 3'h5)
			v[7:5] = 3'h0;
		xfer({1'b0, a, v}, nc);
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		xfer({1'b1, a, 8'h00}, d);
	endtask
endmodule
